// ---- rtl/ubab_pkg.sv ----
// package of constants and types for the serial port with timer based baud generation
package ubab_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [2:0] UBAB_OFF_CTRL = 3'h0;
  localparam logic [2:0] UBAB_OFF_DATA = 3'h1;
  localparam logic [2:0] UBAB_OFF_TMR_CTRL = 3'h2;
  localparam logic [2:0] UBAB_OFF_RELOAD = 3'h3;
  localparam logic [2:0] UBAB_OFF_COUNT = 3'h4;
  localparam logic [2:0] UBAB_OFF_STATUS = 3'h5;
  localparam logic [2:0] UBAB_OFF_MASK = 3'h6;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int UBAB_CTRL_MODE3 = 0;
  localparam int UBAB_CTRL_RX_EN = 1;
  localparam int UBAB_CTRL_TX_BIT8 = 2;
  localparam int UBAB_CTRL_RX_BIT8 = 3;
  localparam int UBAB_TMR_RUN = 0;
  localparam int UBAB_TMR_SRC_LO = 1;
  localparam int UBAB_ST_TX_DONE = 0;
  localparam int UBAB_ST_RX_DONE = 1;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] UBAB_CTRL_RST = 3'h0;
  localparam logic [3:0] UBAB_TMR_CTRL_RST = 4'h0;
  localparam logic [7:0] UBAB_RELOAD_RST = 8'h00;
  localparam logic [7:0] UBAB_COUNT_RST = 8'h00;
  localparam logic [1:0] UBAB_FLAGS_RST = 2'h0;

  // ---------------------------------------------------------------
  // timer clock sources and prescale counts
  // ---------------------------------------------------------------
  localparam logic [2:0] UBAB_SRC_SYS = 3'h0;
  localparam logic [2:0] UBAB_SRC_DIV4 = 3'h1;
  localparam logic [2:0] UBAB_SRC_DIV12 = 3'h2;
  localparam logic [2:0] UBAB_SRC_DIV48 = 3'h3;
  localparam logic [2:0] UBAB_SRC_XOSC8 = 3'h4;
  localparam logic [2:0] UBAB_SRC_PIN = 3'h5;
  localparam logic [5:0] UBAB_PRESC_LAST = 6'h2F;
  localparam logic [1:0] UBAB_DIV4_LAST = 2'h3;
  localparam logic [5:0] UBAB_DIV12_A = 6'h0B;
  localparam logic [5:0] UBAB_DIV12_B = 6'h17;
  localparam logic [5:0] UBAB_DIV12_C = 6'h23;
  localparam logic [2:0] UBAB_XDIV_LAST = 3'h7;
  localparam logic [7:0] UBAB_TMR_TOP = 8'hFF;

  // ---------------------------------------------------------------
  // transmit frame lengths and receive data lengths in bit times
  // ---------------------------------------------------------------
  localparam logic [3:0] UBAB_TX_BITS_M1 = 4'hA;
  localparam logic [3:0] UBAB_TX_BITS_M3 = 4'hB;
  localparam logic [3:0] UBAB_RX_DATA_M1 = 4'h8;
  localparam logic [3:0] UBAB_RX_DATA_M3 = 4'h9;

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    UBAB_TX_IDLE = 2'b01,
    UBAB_TX_RUN = 2'b10
  } ubab_tx_state_t;

  typedef enum logic [3:0] {
    UBAB_RX_IDLE = 4'b0001,
    UBAB_RX_START = 4'b0010,
    UBAB_RX_DATA = 4'b0100,
    UBAB_RX_STOP = 4'b1000
  } ubab_rx_state_t;

endpackage : ubab_pkg

// ---- rtl/ubab_uart.sv ----
// serial port with timer 1 baud generation, receive buffer and interrupt flags
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ubab_uart
  import ubab_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // serial pins
  input wire logic rx_pin,
  output logic tx_pin,
  // timer clock inputs
  input wire logic ext_osc_in,
  input wire logic timer1_external_input,
  // interrupt
  output logic irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] serial_control;
    logic [3:0] tmr_ctrl;
    logic [7:0] timer1_reload_high;
    logic [7:0] timer1_count_low;
    logic [7:0] rx_timer;
    logic [1:0] status;
    logic [1:0] mask;
    logic [5:0] presc;
    logic [2:0] xdiv;
    logic xin_q;
    logic t1in_q;
    logic rx_q;
    logic tx_div;
    logic rx_div;
    ubab_tx_state_t tx_state;
    logic [10:0] tx_shift;
    logic [3:0] tx_cnt;
    ubab_rx_state_t rx_state;
    logic [8:0] rx_shift;
    logic [3:0] rx_cnt;
    logic [7:0] serial_data_buffer;
    logic rx_bit8;
    logic tx_pin;
    logic irq;
    logic [7:0] rdata;
  } ubab_state_t;

  ubab_state_t s_reg;
  ubab_state_t s_next;

  // ---------------------------------------------------------------
  // combinational next state
  // ---------------------------------------------------------------
  always_comb begin
    logic run;
    logic mode3;
    logic [2:0] src;
    logic t1_tick;
    logic tx_ovf;
    logic rx_ovf;
    logic tx_baud;
    logic rx_samp;
    logic start_det;
    logic xin_edge;
    logic [1:0] set_flags;
    logic [1:0] clr_flags;
    logic [3:0] tx_bits;
    logic [3:0] rx_bits;
    run = 1'b0;
    mode3 = 1'b0;
    src = 3'h0;
    t1_tick = 1'b0;
    tx_ovf = 1'b0;
    rx_ovf = 1'b0;
    tx_baud = 1'b0;
    rx_samp = 1'b0;
    start_det = 1'b0;
    xin_edge = 1'b0;
    set_flags = 2'h0;
    clr_flags = 2'h0;
    tx_bits = 4'h0;
    rx_bits = 4'h0;
    s_next = s_reg;

    // ---------------------------------------------------------------
    // timer and mode controls
    // ---------------------------------------------------------------
    run = s_reg.tmr_ctrl[UBAB_TMR_RUN];
    src = s_reg.tmr_ctrl[UBAB_TMR_SRC_LO +: 3];
    mode3 = s_reg.serial_control[UBAB_CTRL_MODE3];

    // ---------------------------------------------------------------
    // frame lengths and receive data bit counts
    // ---------------------------------------------------------------
    tx_bits = mode3 ? UBAB_TX_BITS_M3 : UBAB_TX_BITS_M1;
    rx_bits = mode3 ? UBAB_RX_DATA_M3 : UBAB_RX_DATA_M1;

    // ---------------------------------------------------------------
    // timer 1 clock source
    // ---------------------------------------------------------------
    s_next.presc = (s_reg.presc == UBAB_PRESC_LAST) ? 6'h00 : s_reg.presc + 6'h01;

    // ---------------------------------------------------------------
    // external clock edges
    // ---------------------------------------------------------------
    s_next.xin_q = ext_osc_in;
    s_next.t1in_q = timer1_external_input;
    xin_edge = ext_osc_in & ~s_reg.xin_q;
    if (xin_edge) begin
      s_next.xdiv = s_reg.xdiv + 3'h1;
    end

    // ---------------------------------------------------------------
    // source select
    // ---------------------------------------------------------------
    case (src)
      UBAB_SRC_SYS: t1_tick = 1'b1;
      UBAB_SRC_DIV4: t1_tick = (s_reg.presc[1:0] == UBAB_DIV4_LAST);
      UBAB_SRC_DIV12: t1_tick = (s_reg.presc == UBAB_DIV12_A) || (s_reg.presc == UBAB_DIV12_B) ||
                                (s_reg.presc == UBAB_DIV12_C) || (s_reg.presc == UBAB_PRESC_LAST);
      UBAB_SRC_DIV48: t1_tick = (s_reg.presc == UBAB_PRESC_LAST);
      UBAB_SRC_XOSC8: t1_tick = xin_edge && (s_reg.xdiv == UBAB_XDIV_LAST);
      UBAB_SRC_PIN: t1_tick = s_reg.t1in_q & ~timer1_external_input;
      default: t1_tick = 1'b0;
    endcase
    t1_tick = t1_tick & run;

    // ---------------------------------------------------------------
    // receive line sample and start bit detection
    // ---------------------------------------------------------------
    s_next.rx_q = rx_pin;
    start_det = (s_reg.rx_state == UBAB_RX_IDLE) && s_reg.serial_control[UBAB_CTRL_RX_EN] &&
                run && s_reg.rx_q && !rx_pin;

    // ---------------------------------------------------------------
    // timer count and reload
    // ---------------------------------------------------------------
    if (t1_tick) begin
      if (s_reg.timer1_count_low == UBAB_TMR_TOP) begin
        s_next.timer1_count_low = s_reg.timer1_reload_high;
        tx_ovf = 1'b1;
      end else begin
        s_next.timer1_count_low = s_reg.timer1_count_low + 8'h01;
      end
      if (s_reg.rx_timer == UBAB_TMR_TOP) begin
        s_next.rx_timer = s_reg.timer1_reload_high;
        rx_ovf = 1'b1;
      end else begin
        s_next.rx_timer = s_reg.rx_timer + 8'h01;
      end
    end

    // ---------------------------------------------------------------
    // baud dividers
    // ---------------------------------------------------------------
    if (tx_ovf) begin
      s_next.tx_div = ~s_reg.tx_div;
    end
    tx_baud = tx_ovf && s_reg.tx_div;
    if (rx_ovf) begin
      s_next.rx_div = ~s_reg.rx_div;
    end
    rx_samp = rx_ovf && !s_reg.rx_div;

    // ---------------------------------------------------------------
    // start bit realignment
    // ---------------------------------------------------------------
    if (start_det) begin
      s_next.rx_timer = s_reg.timer1_reload_high;
      s_next.rx_div = 1'b0;
    end

    // ---------------------------------------------------------------
    // transmitter
    // ---------------------------------------------------------------
    case (s_reg.tx_state)
      UBAB_TX_IDLE: begin
        s_next.tx_pin = 1'b1;
      end
      UBAB_TX_RUN: begin
        if (tx_baud) begin
          if (s_reg.tx_cnt == tx_bits) begin
            s_next.tx_pin = 1'b1;
            s_next.tx_state = UBAB_TX_IDLE;
            set_flags[UBAB_ST_TX_DONE] = 1'b1;
          end else begin
            s_next.tx_pin = s_reg.tx_shift[0];
            s_next.tx_shift = {1'b1, s_reg.tx_shift[10:1]};
            s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
          end
        end
      end
      default: s_next.tx_state = UBAB_TX_IDLE;
    endcase

    // ---------------------------------------------------------------
    // receiver
    // ---------------------------------------------------------------
    case (s_reg.rx_state)
      UBAB_RX_IDLE: begin
        if (start_det) begin
          s_next.rx_state = UBAB_RX_START;
        end
      end
      UBAB_RX_START: begin
        if (rx_samp) begin
          s_next.rx_cnt = 4'h0;
          s_next.rx_state = rx_pin ? UBAB_RX_IDLE : UBAB_RX_DATA;
        end
      end
      UBAB_RX_DATA: begin
        if (rx_samp) begin
          s_next.rx_shift = {rx_pin, s_reg.rx_shift[8:1]};
          s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
          if (s_reg.rx_cnt == rx_bits - 4'h1) begin
            s_next.rx_state = UBAB_RX_STOP;
          end
        end
      end
      UBAB_RX_STOP: begin
        if (rx_samp) begin
          s_next.rx_state = UBAB_RX_IDLE;
          if (rx_pin) begin
            if (mode3) begin
              s_next.serial_data_buffer = s_reg.rx_shift[7:0];
              s_next.rx_bit8 = s_reg.rx_shift[8];
            end else begin
              s_next.serial_data_buffer = s_reg.rx_shift[8:1];
              s_next.rx_bit8 = rx_pin;
            end
            set_flags[UBAB_ST_RX_DONE] = 1'b1;
          end
        end
      end
      default: s_next.rx_state = UBAB_RX_IDLE;
    endcase

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    if (reg_wr) begin
      case (reg_addr)
        UBAB_OFF_CTRL: s_next.serial_control = reg_wdata[2:0];
        UBAB_OFF_DATA: begin
          s_next.tx_shift = {1'b1, s_reg.serial_control[UBAB_CTRL_TX_BIT8], reg_wdata, 1'b0};
          if (!mode3) begin
            s_next.tx_shift[9] = 1'b1;
          end
          s_next.tx_cnt = 4'h0;
          s_next.tx_pin = s_reg.tx_pin;
          s_next.tx_state = UBAB_TX_RUN;
        end
        UBAB_OFF_TMR_CTRL: s_next.tmr_ctrl = reg_wdata[3:0];
        UBAB_OFF_RELOAD: s_next.timer1_reload_high = reg_wdata;
        UBAB_OFF_COUNT: s_next.timer1_count_low = reg_wdata;
        UBAB_OFF_STATUS: clr_flags = reg_wdata[1:0];
        UBAB_OFF_MASK: s_next.mask = reg_wdata[1:0];
        default: s_next.mask = s_reg.mask;
      endcase
    end

    // ---------------------------------------------------------------
    // interrupt flags, a hardware set wins over a software clear
    // ---------------------------------------------------------------
    for (int f = 0; f < 2; f++) begin
      if (set_flags[f]) begin
        s_next.status[f] = 1'b1;
      end else if (clr_flags[f]) begin
        s_next.status[f] = 1'b0;
      end
    end
    s_next.irq = |(s_next.status & s_next.mask);

    // ---------------------------------------------------------------
    // register reads
    // ---------------------------------------------------------------
    s_next.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        UBAB_OFF_CTRL: s_next.rdata = {4'h0, s_reg.rx_bit8, s_reg.serial_control};
        UBAB_OFF_DATA: s_next.rdata = s_reg.serial_data_buffer;
        UBAB_OFF_TMR_CTRL: s_next.rdata = {4'h0, s_reg.tmr_ctrl};
        UBAB_OFF_RELOAD: s_next.rdata = s_reg.timer1_reload_high;
        UBAB_OFF_COUNT: s_next.rdata = s_reg.timer1_count_low;
        UBAB_OFF_STATUS: s_next.rdata = {6'h00, s_reg.status};
        UBAB_OFF_MASK: s_next.rdata = {6'h00, s_reg.mask};
        default: s_next.rdata = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.serial_control <= UBAB_CTRL_RST;
      s_reg.tmr_ctrl <= UBAB_TMR_CTRL_RST;
      s_reg.timer1_reload_high <= UBAB_RELOAD_RST;
      s_reg.timer1_count_low <= UBAB_COUNT_RST;
      s_reg.rx_timer <= UBAB_COUNT_RST;
      s_reg.status <= UBAB_FLAGS_RST;
      s_reg.mask <= UBAB_FLAGS_RST;
      s_reg.tx_state <= UBAB_TX_IDLE;
      s_reg.rx_state <= UBAB_RX_IDLE;
      s_reg.tx_shift <= 11'h7FF;
      s_reg.tx_pin <= 1'b1;
      s_reg.rx_q <= 1'b1;
      s_reg.presc <= 6'h00;
      s_reg.xdiv <= 3'h0;
      s_reg.xin_q <= 1'b0;
      s_reg.t1in_q <= 1'b0;
      s_reg.tx_div <= 1'b0;
      s_reg.rx_div <= 1'b0;
      s_reg.tx_cnt <= 4'h0;
      s_reg.rx_shift <= 9'h000;
      s_reg.rx_cnt <= 4'h0;
      s_reg.serial_data_buffer <= 8'h00;
      s_reg.rx_bit8 <= 1'b0;
      s_reg.irq <= 1'b0;
      s_reg.rdata <= 8'h00;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata = s_reg.rdata;
  assign tx_pin = s_reg.tx_pin;
  assign irq = s_reg.irq;

endmodule : ubab_uart
`default_nettype wire

// ---- verif/ubab_uart_assertions.sv ----
// port checker for the serial port
`timescale 1ns/1ps
`default_nettype none
module ubab_uart_chk
  import ubab_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins
  input wire logic rx_pin,
  input wire logic tx_pin,
  input wire logic ext_osc_in,
  input wire logic timer1_external_input,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // ----
  // assertions
  // ----
  chk_reset_quiet: assert property ($fell(srst) |-> !irq && tx_pin && reg_rdata == 8'h00)
    else $error("outputs not quiet after reset");
  chk_read_window: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
    else $error("read data outside read cycle");
  chk_unmapped_zero: assert property (reg_rd && reg_addr == 3'h7 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_mask_blocks: assert property (
    reg_wr && reg_addr == UBAB_OFF_MASK && reg_wdata == 8'h00 |=> !irq)
    else $error("irq high with mask cleared");
  chk_flag_sticky: assert property (irq && !reg_wr && !$past(reg_wr) |=> irq)
    else $error("irq dropped without software clear");
  chk_status_cause: assert property (
    reg_rd && reg_addr == UBAB_OFF_STATUS && irq && !$past(reg_wr) |=> reg_rdata[1:0] != 2'h0)
    else $error("irq high with empty status");
  chk_write_idle: assert property (reg_wr && reg_addr == UBAB_OFF_DATA && tx_pin |=> tx_pin)
    else $error("tx line moved on the write cycle");
  chk_bit_hold: assert property ($changed(tx_pin) |=> $stable(tx_pin))
    else $error("tx bit shorter than two cycles");
  cover property ($rose(irq));
  cover property ($fell(tx_pin));
  cover property (reg_rd && reg_addr == UBAB_OFF_DATA ##1 reg_rdata != 8'h00);
endmodule : ubab_uart_chk
bind ubab_uart ubab_uart_chk i_chk (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rx_pin(rx_pin), .tx_pin(tx_pin), .ext_osc_in(ext_osc_in),
  .timer1_external_input(timer1_external_input), .irq(irq));
`default_nettype wire

// ---- verif/ubab_serial_peer.sv ----
// far end serial transceiver model
`timescale 1ns/1ps
`default_nettype none
module ubab_serial_peer (
  // clock
  input wire logic ref_clk,
  // serial lines
  output logic rx_line,
  input wire logic tx_line
);
  initial rx_line = 1'b1;
  // send one frame, bc cycles per bit
  task automatic send(input logic [8:0] d, input int nb, input logic stp, input int bc);
    rx_line <= 1'b0;
    repeat (bc) @(posedge ref_clk);
    for (int i = 0; i < nb; i++) begin
      rx_line <= d[i];
      repeat (bc) @(posedge ref_clk);
    end
    rx_line <= stp;
    repeat (bc) @(posedge ref_clk);
    if (!stp) begin
      rx_line <= 1'b1;
      @(posedge ref_clk);
    end
  endtask : send
  // take one frame, sampling mid bit
  task automatic recv(output logic [8:0] d, output logic ok, input int nb, input int bc);
    int n;
    d = 9'h000;
    n = 0;
    while (tx_line === 1'b1 && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    repeat (bc / 2) @(negedge ref_clk);
    ok = (tx_line === 1'b0) && n < 20000;
    for (int i = 0; i < nb; i++) begin
      repeat (bc) @(negedge ref_clk);
      d[i] = tx_line;
    end
    repeat (bc) @(negedge ref_clk);
    ok = ok && tx_line === 1'b1;
  endtask : recv
endmodule : ubab_serial_peer
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ubab_pkg::*;
;
  typedef struct {logic [2:0] a; logic [7:0] w; logic [7:0] e;} ubab_row_t;
  logic ref_clk, srst, reg_wr, reg_rd, ext_osc_in, t1_in, rx_line, tx_pin, irq, ok;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic [8:0] d;
  int n_errors, samples_checked, n;
  int dv [6] = '{1, 4, 12, 48, 16, 2};
  ubab_row_t rows [7] = '{'{UBAB_OFF_CTRL, 8'h07, 8'h07}, '{UBAB_OFF_TMR_CTRL, 8'h0A, 8'h0A},
    '{UBAB_OFF_RELOAD, 8'hA5, 8'hA5}, '{UBAB_OFF_COUNT, 8'h5A, 8'h5A},
    '{UBAB_OFF_MASK, 8'h03, 8'h03}, '{UBAB_OFF_DATA, 8'h3C, 8'h00}, '{3'h7, 8'hFF, 8'h00}};
  ubab_uart i_dut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pin(rx_line),
    .tx_pin(tx_pin), .ext_osc_in(ext_osc_in), .timer1_external_input(t1_in), .irq(irq));
  ubab_serial_peer peer (.ref_clk(ref_clk), .rx_line(rx_line), .tx_line(tx_pin));
  // ----
  // tasks
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] w);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] r);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    r = reg_rdata;
  endtask : rd
  task automatic wrap_up();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task automatic wait_irq();
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 30000) begin
      @(negedge ref_clk);
      k++;
    end
    if (k >= 30000) begin
      n_errors++;
      wrap_up();
    end
  endtask : wait_irq
  // ----
  // stimulus
  // ----
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    ext_osc_in <= !ext_osc_in;
    t1_in <= !t1_in;
  end
  initial begin
    {srst, reg_wr, reg_rd, ext_osc_in, t1_in} = 5'h11;
    {reg_addr, reg_wdata} = 11'h000;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, v);
      chk({8'h00, v}, {8'h00, rows[i].e});
    end
    chk({15'h0000, irq}, 16'h0000);
    wr(UBAB_OFF_RELOAD, 8'hFF);
    wr(UBAB_OFF_MASK, 8'h01);
    for (int s = 0; s < 6; s++) begin
      wr(UBAB_OFF_TMR_CTRL, {4'h0, s[2:0], 1'b1});
      wr(UBAB_OFF_DATA, 8'h00);
      n = 0;
      while (tx_pin === 1'b1 && n < 9000) begin
        @(negedge ref_clk);
        n++;
      end
      n = 0;
      while (tx_pin === 1'b0 && n < 9000) begin
        @(negedge ref_clk);
        n++;
      end
      chk(n[15:0], 16'(18 * dv[s]));
      wait_irq();
      wr(UBAB_OFF_STATUS, 8'h01);
    end
    wr(UBAB_OFF_RELOAD, 8'hFC);
    wr(UBAB_OFF_TMR_CTRL, 8'h01);
    for (int m = 0; m < 2; m++) begin
      wr(UBAB_OFF_CTRL, {5'h00, 1'b1, 1'b0, m[0]});
      wr(UBAB_OFF_DATA, 8'hA6);
      peer.recv(d, ok, 8 + m, 8);
      chk({6'h00, ok, d}, {6'h00, 1'b1, m[0], 8'hA6});
      wait_irq();
      rd(UBAB_OFF_STATUS, v);
      chk({8'h00, v}, 16'h0001);
      repeat (50) @(negedge ref_clk);
      chk({15'h0000, irq}, 16'h0001);
      wr(UBAB_OFF_MASK, 8'h00);
      repeat (3) @(negedge ref_clk);
      chk({15'h0000, irq}, 16'h0000);
      wr(UBAB_OFF_MASK, 8'h01);
      repeat (3) @(negedge ref_clk);
      chk({15'h0000, irq}, 16'h0001);
      wr(UBAB_OFF_STATUS, 8'h01);
      repeat (3) @(negedge ref_clk);
      chk({15'h0000, irq}, 16'h0000);
    end
    wr(UBAB_OFF_CTRL, 8'h02);
    wr(UBAB_OFF_MASK, 8'h02);
    fork
      begin
        repeat (3) @(posedge ref_clk);
        peer.send(9'h0C3, 8, 1'b1, 8);
        peer.send(9'h05A, 8, 1'b1, 8);
      end
      begin
        wait_irq();
        repeat (20) @(negedge ref_clk);
        rd(UBAB_OFF_DATA, v);
        chk({8'h00, v}, 16'h00C3);
        wr(UBAB_OFF_STATUS, 8'h02);
        repeat (4) @(negedge ref_clk);
        wait_irq();
        rd(UBAB_OFF_DATA, v);
        chk({8'h00, v}, 16'h005A);
      end
    join
    wr(UBAB_OFF_STATUS, 8'h02);
    wr(UBAB_OFF_CTRL, 8'h03);
    peer.send(9'h181, 9, 1'b1, 8);
    wait_irq();
    rd(UBAB_OFF_DATA, v);
    chk({8'h00, v}, 16'h0081);
    rd(UBAB_OFF_CTRL, v);
    chk({8'h00, v}, 16'h000B);
    wr(UBAB_OFF_STATUS, 8'h02);
    peer.send(9'h0F0, 9, 1'b0, 8);
    repeat (40) @(negedge ref_clk);
    rd(UBAB_OFF_STATUS, v);
    chk({8'h00, v}, 16'h0000);
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(i[2:0], v);
      chk({8'h00, v}, 16'h0000);
    end
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
